// file: rtl/qp_pkg.sv
// Shared constants for the quad potentiometer command core
package qp_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int NV_SAVE_TIME_MS = 5;
   localparam int NV_SAVE_CYC = NV_SAVE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SETTLE_MIN_US = 5;
   localparam int SETTLE_MAX_US = 10;
   localparam int SETTLE_CYC = (SETTLE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W = 9;
   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int CHANNELS = 4;
   localparam int SLOTS = 4;
   localparam int TAPS = 256;
   // ------------------------------------------------------------
   // Frame bit positions (count of rising edges minus one)
   // ------------------------------------------------------------
   localparam logic [4:0] ADDR_BYTE_END = 5'h07;
   localparam logic [4:0] INSTR_BYTE_END = 5'h0F;
   localparam logic [4:0] DATA_FIRST = 5'h10;
   localparam logic [4:0] DATA_BYTE_END = 5'h17;
   localparam logic [4:0] CNT_MAX = 5'h18;
   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [3:0] OP_RD_WIPER = 4'h9;
   localparam logic [3:0] OP_WR_WIPER = 4'hA;
   localparam logic [3:0] OP_RD_SLOT = 4'hB;
   localparam logic [3:0] OP_WR_SLOT = 4'hC;
   localparam logic [3:0] OP_SLOT_TO_WIPER = 4'hD;
   localparam logic [3:0] OP_WIPER_TO_SLOT = 4'hE;
   localparam logic [3:0] OP_GLB_SLOT_TO_WIPER = 4'h1;
   localparam logic [3:0] OP_GLB_WIPER_TO_SLOT = 4'h8;
   localparam logic [3:0] OP_STEP = 4'h2;
   localparam logic [3:0] OP_STATUS = 4'h5;
   // ------------------------------------------------------------
   // Reset and initial values
   // ------------------------------------------------------------
   localparam logic [7:0] WIPER_RST = 8'h00;
   localparam logic [7:0] SLOT_INIT = 8'h00;
   localparam logic [TAPS-1:0] TAP_RST = 256'h1;
endpackage

// file: rtl/qp_link_if.sv
// Carrier between the serial link logic and the register core
`timescale 1ns/1ps
`default_nettype none
interface qp_link_if;
   logic [3:0][7:0] snap_wiper;
   logic snap_busy;
   logic [127:0] slot_flat;
   logic [1:0] strap;
   logic [3:0] cmd_op;
   logic [1:0] cmd_slot;
   logic [1:0] cmd_chan;
   logic [7:0] cmd_data;
   logic cmd_tgl;
   logic up_tgl;
   logic dn_tgl;
   modport link (
      input snap_wiper, snap_busy, slot_flat, strap,
      output cmd_op, cmd_slot, cmd_chan, cmd_data, cmd_tgl, up_tgl, dn_tgl
   );
   modport core (
      output snap_wiper, snap_busy, slot_flat, strap,
      input cmd_op, cmd_slot, cmd_chan, cmd_data, cmd_tgl, up_tgl, dn_tgl
   );
endinterface
`default_nettype wire

// file: rtl/qp_spi_link.sv
// Serial framing logic on the host's shift clock
`timescale 1ns/1ps
`default_nettype none
module qp_spi_link
   import qp_pkg::*;
#(
   parameter logic [3:0] DEV_TYPE = 4'hA
) (
   // Link pins
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_n_o,
   // Reset
   input wire logic sys_rst_i,
   // To core
   qp_link_if.link lk
);
   typedef struct packed {
      logic [4:0] cnt;
      logic [6:0] sh;
      logic ignore;
      logic step;
      logic [3:0] op;
      logic [1:0] slot;
      logic [1:0] chan;
   } qp_link_st_t;

   qp_link_st_t r, n;
   logic frame_rst;
   logic [7:0] byte_in;
   logic issue, load, up_ev, dn_ev, rd_cmd;
   logic [3:0] ld_op;
   logic [1:0] ld_slot, ld_chan;
   logic [7:0] rd_byte;

   // Frame state lives only between chip select edges
   assign frame_rst = cs_n_i | sys_rst_i;
   assign byte_in = {r.sh, si_i};

   always_comb begin
      n = r;
      issue = 1'b0;
      load = 1'b0;
      up_ev = 1'b0;
      dn_ev = 1'b0;
      ld_op = r.op;
      ld_slot = r.slot;
      ld_chan = r.chan;
      n.sh = byte_in[6:0];
      n.cnt = (r.cnt == CNT_MAX) ? CNT_MAX : r.cnt + 5'h01;
      if (!r.ignore) begin
         case (r.cnt)
            ADDR_BYTE_END: begin
               if (byte_in[7:4] != DEV_TYPE || byte_in[1:0] != lk.strap) begin
                  n.ignore = 1'b1;
               end
            end
            INSTR_BYTE_END: begin
               ld_op = byte_in[7:4];
               ld_slot = byte_in[3:2];
               ld_chan = byte_in[1:0];
               n.op = ld_op;
               n.slot = ld_slot;
               n.chan = ld_chan;
               case (ld_op)
                  OP_SLOT_TO_WIPER, OP_WIPER_TO_SLOT,
                  OP_GLB_SLOT_TO_WIPER, OP_GLB_WIPER_TO_SLOT: begin
                     issue = 1'b1;
                     load = 1'b1;
                  end
                  OP_STEP: begin
                     n.step = 1'b1;
                     load = 1'b1;
                  end
                  default: ;
               endcase
            end
            DATA_BYTE_END: begin
               if (r.op == OP_WR_WIPER || r.op == OP_WR_SLOT) begin
                  issue = 1'b1;
                  load = 1'b1;
               end
            end
            default: ;
         endcase
         if (r.step && r.cnt >= DATA_FIRST) begin
            up_ev = si_i;
            dn_ev = !si_i;
         end
      end
   end

   always_ff @(posedge sck_i or posedge frame_rst) begin
      if (frame_rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // Command words outlive the frame; the toggles hand them to the core
   always_ff @(posedge sck_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lk.cmd_op <= 4'h0;
         lk.cmd_slot <= 2'h0;
         lk.cmd_chan <= 2'h0;
         lk.cmd_data <= 8'h00;
         lk.cmd_tgl <= 1'b0;
         lk.up_tgl <= 1'b0;
         lk.dn_tgl <= 1'b0;
      end else begin
         if (load) begin
            lk.cmd_op <= ld_op;
            lk.cmd_slot <= ld_slot;
            lk.cmd_chan <= ld_chan;
            lk.cmd_data <= byte_in;
         end
         lk.cmd_tgl <= lk.cmd_tgl ^ issue;
         lk.up_tgl <= lk.up_tgl ^ up_ev;
         lk.dn_tgl <= lk.dn_tgl ^ dn_ev;
      end
   end

   // ------------------------------------------------------------
   // Read data, launched on falling edges
   // ------------------------------------------------------------
   assign rd_cmd = (r.op == OP_RD_WIPER) || (r.op == OP_RD_SLOT) || (r.op == OP_STATUS);

   always_comb begin
      case (r.op)
         OP_RD_WIPER: rd_byte = lk.snap_wiper[r.chan];
         OP_RD_SLOT: rd_byte = lk.slot_flat[{r.chan, r.slot, 3'h0} +: 8];
         OP_STATUS: rd_byte = {7'h00, lk.snap_busy};
         default: rd_byte = 8'h00;
      endcase
   end

   // Mismatched devices never leave high impedance
   always_ff @(negedge sck_i or posedge frame_rst) begin
      if (frame_rst) begin
         so_o <= 1'b0;
         so_oe_n_o <= 1'b1;
      end else if (rd_cmd && !r.ignore && r.cnt >= DATA_FIRST && r.cnt < CNT_MAX) begin
         so_o <= rd_byte[~r.cnt[2:0]];
         so_oe_n_o <= 1'b0;
      end else begin
         so_o <= 1'b0;
         so_oe_n_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: rtl/qp_core.sv
// Quad potentiometer serial command core, top level
//
// Behaviour
// - Each command opens with an address byte whose top four bits match the type code.
// - The command continues only if the low two address bits match the straps.
// - Only the device whose strap address matches executes; others stay idle.
// - Second byte carries the instruction; its top four bits are the opcode.
// - Instruction bits three and two pick stored slot zero to three.
// - Instruction bits one and zero pick the wiper channel.
// - Four independent 8-bit wiper position registers, one per channel.
// - Each wiper position closes exactly one of 256 tap switches.
// - Wipers change only by write, slot transfer, step or power-up recall.
// - At power-up each wiper loads from its slot zero.
// - Wipers are volatile; only the slot-zero recall restores them.
// - Each channel has four 8-bit nonvolatile slots, host readable and writable.
// - Copies run both ways between any slot and its wiper.
// - A slot change is a save lasting at most 5 ms.
// - Wiper follows a new value 5 to 10 us after the instruction, sooner if an earlier change is still settling.
// - After supply is stable the recalled wiper appears 5 to 10 us later.
// - Opcode set for reads, writes, transfers, globals, step mode and status.
// - In step mode each clock moves the wiper up if input high, else down.
// - Slot saves start at chip select rise; status then reports busy as 1.
`timescale 1ns/1ps
`default_nettype none
module qp_core
   import qp_pkg::*;
#(
   parameter logic [3:0] DEV_TYPE = 4'hA, // arbitrary value
   parameter int NV_SAVE_CYCLES = NV_SAVE_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Serial link
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_n_o,
   // Address straps
   input wire logic strap_select_hi_i,
   input wire logic strap_select_lo_i,
   // Tap switches, channel c at bits c*256 upward
   output logic [CHANNELS*TAPS-1:0] tap_o,
   // Save in progress
   output logic nv_save_busy_o
);
   localparam int NW = $clog2(NV_SAVE_CYCLES + 1);
   localparam logic [NW-1:0] NV_LAST = NW'(NV_SAVE_CYCLES - 1);
   localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYC - 1);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic cs1;
      logic cs2;
      logic cs3;
      logic [1:0] st1;
      logic [1:0] st2;
      logic cmd1;
      logic cmd2;
      logic cmd3;
      logic up1;
      logic up2;
      logic up3;
      logic dn1;
      logic dn2;
      logic dn3;
      logic recall;
      logic [3:0][7:0] wiper;
      logic [3:0][7:0] shown;
      logic [3:0][TAPS-1:0] tap;
      logic settling;
      logic [SETTLE_W-1:0] settle_cnt;
      logic pend;
      logic [3:0] pend_op;
      logic [1:0] pend_slot;
      logic [1:0] pend_chan;
      logic [7:0] pend_data;
      logic busy;
      logic [NW-1:0] nv_cnt;
      logic [3:0][7:0] snap_wiper;
      logic snap_busy;
   } qp_core_st_t;

   qp_core_st_t r, n;
   qp_link_if lk ();

   logic [CHANNELS*SLOTS-1:0] slot_we;
   logic [3:0][7:0] slot_wd;
   logic [7:0] slot_mem [CHANNELS*SLOTS] = '{default: SLOT_INIT};
   logic cmd_ev, up_ev, dn_ev, cs_rise;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [TAPS-1:0] qp_tap_decode(input logic [7:0] pos);
      logic [TAPS-1:0] t;
      t = '0;
      t[pos] = 1'b1;
      return t;
   endfunction

   function automatic logic qp_is_nv_op(input logic [3:0] op);
      return (op == OP_WR_SLOT) || (op == OP_WIPER_TO_SLOT) ||
         (op == OP_GLB_WIPER_TO_SLOT);
   endfunction

   // ------------------------------------------------------------
   // Link side
   // ------------------------------------------------------------
   qp_spi_link #(
      .DEV_TYPE(DEV_TYPE)
   ) u_link (
      .sck_i(sck_i),
      .cs_n_i(cs_n_i),
      .si_i(si_i),
      .so_o(so_o),
      .so_oe_n_o(so_oe_n_o),
      .sys_rst_i(sys_rst_i),
      .lk(lk.link)
   );

   // Snapshot only moves while deselected, so frames see stable words
   assign lk.snap_wiper = r.snap_wiper;
   assign lk.snap_busy = r.snap_busy;
   assign lk.strap = r.st2;

   for (genvar i = 0; i < CHANNELS * SLOTS; i++) begin : g_flat
      assign lk.slot_flat[i*8 +: 8] = slot_mem[i];
   end

   // Event edges are taken after the second synchroniser stage only
   assign cmd_ev = r.cmd2 ^ r.cmd3;
   assign up_ev = r.up2 ^ r.up3;
   assign dn_ev = r.dn2 ^ r.dn3;
   assign cs_rise = r.cs2 & ~r.cs3;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      n = r;
      slot_we = '0;
      slot_wd = '0;
      n.cs1 = cs_n_i;
      n.cs2 = r.cs1;
      n.cs3 = r.cs2;
      n.st1 = {strap_select_hi_i, strap_select_lo_i};
      n.st2 = r.st1;
      n.cmd1 = lk.cmd_tgl;
      n.cmd2 = r.cmd1;
      n.cmd3 = r.cmd2;
      n.up1 = lk.up_tgl;
      n.up2 = r.up1;
      n.up3 = r.up2;
      n.dn1 = lk.dn_tgl;
      n.dn2 = r.dn1;
      n.dn3 = r.dn2;

      // Power-up recall, one cycle after reset release
      if (r.recall) begin
         n.recall = 1'b0;
         for (int c = 0; c < CHANNELS; c++) begin
            n.wiper[c] = slot_mem[c*SLOTS];
         end
      end

      // Decoded commands from the link
      if (cmd_ev) begin
         case (lk.cmd_op)
            OP_WR_WIPER: n.wiper[lk.cmd_chan] = lk.cmd_data;
            OP_SLOT_TO_WIPER: begin
               n.wiper[lk.cmd_chan] = slot_mem[{lk.cmd_chan, lk.cmd_slot}];
            end
            OP_GLB_SLOT_TO_WIPER: begin
               for (int c = 0; c < CHANNELS; c++) begin
                  n.wiper[c] = slot_mem[c*SLOTS + int'(lk.cmd_slot)];
               end
            end
            OP_WR_SLOT, OP_WIPER_TO_SLOT, OP_GLB_WIPER_TO_SLOT: begin
               // A save in flight refuses further slot changes
               if (!r.busy) begin
                  n.pend = 1'b1;
                  n.pend_op = lk.cmd_op;
                  n.pend_slot = lk.cmd_slot;
                  n.pend_chan = lk.cmd_chan;
                  n.pend_data = lk.cmd_data;
               end
            end
            default: ;
         endcase
      end

      // Single steps, clamped at both ends
      if (up_ev && r.wiper[lk.cmd_chan] != 8'hFF) begin
         n.wiper[lk.cmd_chan] = r.wiper[lk.cmd_chan] + 8'h01;
      end
      if (dn_ev && r.wiper[lk.cmd_chan] != 8'h00) begin
         n.wiper[lk.cmd_chan] = r.wiper[lk.cmd_chan] - 8'h01;
      end

      // Save starts when the frame closes
      if (cs_rise && r.pend && qp_is_nv_op(r.pend_op)) begin
         n.pend = 1'b0;
         n.busy = 1'b1;
         n.nv_cnt = '0;
         for (int c = 0; c < CHANNELS; c++) begin
            if (r.pend_op == OP_GLB_WIPER_TO_SLOT || int'(r.pend_chan) == c) begin
               slot_we[c*SLOTS + int'(r.pend_slot)] = 1'b1;
            end
            slot_wd[c] = (r.pend_op == OP_WR_SLOT) ? r.pend_data : r.wiper[c];
         end
      end else if (r.busy) begin
         if (r.nv_cnt == NV_LAST) begin
            n.busy = 1'b0;
         end else begin
            n.nv_cnt = r.nv_cnt + 1'b1;
         end
      end

      // Wiper settle delay before the switches follow
      if (!r.settling) begin
         if (r.wiper != r.shown) begin
            n.settling = 1'b1;
            n.settle_cnt = '0;
         end
      end else if (r.settle_cnt == SETTLE_LAST) begin
         n.settling = 1'b0;
         n.shown = r.wiper;
         for (int c = 0; c < CHANNELS; c++) begin
            n.tap[c] = qp_tap_decode(r.wiper[c]);
         end
      end else begin
         n.settle_cnt = r.settle_cnt + 1'b1;
      end

      if (r.cs2) begin
         n.snap_wiper = r.wiper;
         n.snap_busy = r.busy;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         r <= '0;
         r.cs1 <= 1'b1;
         r.cs2 <= 1'b1;
         r.cs3 <= 1'b1;
         r.recall <= 1'b1;
         r.wiper <= {CHANNELS{WIPER_RST}};
         r.shown <= {CHANNELS{WIPER_RST}};
         r.snap_wiper <= {CHANNELS{WIPER_RST}};
         r.tap <= {CHANNELS{TAP_RST}};
      end else begin
         r <= n;
      end
   end

   // Nonvolatile slots keep their contents across reset
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < CHANNELS * SLOTS; i++) begin
         if (slot_we[i]) begin
            slot_mem[i] <= slot_wd[i / SLOTS];
         end
      end
   end

   assign tap_o = r.tap;
   assign nv_save_busy_o = r.busy;
endmodule
`default_nettype wire

// file: verification/qp_core_assertions.sv
// Port-level checks for the quad potentiometer core
`timescale 1ns/1ps
`default_nettype none
module qp_core_checker
   import qp_pkg::*;
#(
   parameter int NV_SAVE_CYCLES = NV_SAVE_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Link and straps
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic so_o,
   input wire logic so_oe_n_o,
   input wire logic strap_select_hi_i,
   input wire logic strap_select_lo_i,
   // Outputs
   input wire logic [CHANNELS*TAPS-1:0] tap_o,
   input wire logic nv_save_busy_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   logic [19:0] busy_cnt_r;
   logic [8:0] gap_r;
   logic [CHANNELS*TAPS-1:0] tap_prev_r;
   // ----------
   // Save length and tap spacing counters
   // ----------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         busy_cnt_r <= 20'h00000;
         gap_r <= 9'h000;
         tap_prev_r <= {CHANNELS{TAP_RST}};
      end else begin
         busy_cnt_r <= nv_save_busy_o ? busy_cnt_r + 20'h00001 : 20'h00000;
         gap_r <= (tap_o != tap_prev_r) ? 9'h000 : gap_r + {8'h00, ~&gap_r};
         tap_prev_r <= tap_o;
      end
   end
   // ----------
   // Assertions
   // ----------
   for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
      chk_tap_onehot: assert property ($onehot(tap_o[c*TAPS +: TAPS]))
         else $error("Tap select is not one-hot");
   end
   chk_oe_idle: assert property (cs_n_i [*3] |-> so_oe_n_o)
      else $error("Serial output enabled while deselected");
   chk_so_quiet: assert property (so_oe_n_o |-> !so_o)
      else $error("Serial output not low while disabled");
   chk_oe_start: assert property ($fell(so_oe_n_o) |-> !cs_n_i && !sck_i)
      else $error("Output enable not on a falling shift edge");
   chk_so_held: assert property (!so_oe_n_o && sck_i && $past(sck_i) |-> $stable(so_o))
      else $error("Serial output moved while shift clock high");
   chk_busy_cs: assert property ($rose(nv_save_busy_o) |-> cs_n_i && $past(cs_n_i, 2))
      else $error("Save started inside a frame");
   chk_busy_len: assert property ($fell(nv_save_busy_o) |->
      busy_cnt_r >= NV_SAVE_CYCLES - 1 && busy_cnt_r <= NV_SAVE_CYCLES + 1)
      else $error("Save busy length wrong");
   chk_tap_gap: assert property (!$stable(tap_o) |-> gap_r >= 9'h0C7)
      else $error("Tap update sooner than settle time");
endmodule
bind qp_core qp_core_checker #(.NV_SAVE_CYCLES(NV_SAVE_CYCLES)) i_qp_core_checker (
   .clk_i(clk_i),
   .sys_rst_i(sys_rst_i),
   .sck_i(sck_i),
   .cs_n_i(cs_n_i),
   .si_i(si_i),
   .so_o(so_o),
   .so_oe_n_o(so_oe_n_o),
   .strap_select_hi_i(strap_select_hi_i),
   .strap_select_lo_i(strap_select_lo_i),
   .tap_o(tap_o),
   .nv_save_busy_o(nv_save_busy_o)
);
`default_nettype wire

// file: verification/qp_host_model.sv
// Serial host model driving the potentiometer link
`timescale 1ns/1ps
`default_nettype none
module qp_host_model (
   // Link
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o,
   input wire logic so_i,
   input wire logic so_oe_n_i,
   // Read result
   output logic rd_stb_o,
   output logic [7:0] rd_byte_o
);
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
      rd_stb_o = 1'b0;
      rd_byte_o = 8'h00;
   end
   // ----------
   // One frame; shift clock stands low outside it
   // ----------
   task automatic frame(input logic [31:0] w, input int n, input bit rd);
      #7;
      cs_n_o = 1'b0;
      #250;
      for (int i = 0; i < n; i++) begin
         si_o = w[31-i];
         #80;
         sck_o = 1'b1;
         // Undriven output reads as unknown so it never matches data
         if (i > 15)
            rd_byte_o = {rd_byte_o[6:0], so_oe_n_i ? 1'bx : so_i};
         #80;
         sck_o = 1'b0;
      end
      #250;
      cs_n_o = 1'b1;
      // Released data line flips so a stale bit cannot pass
      si_o = ~si_o;
      if (rd) begin
         rd_stb_o = 1'b1;
         #1;
         rd_stb_o = 1'b0;
      end
      #400;
   endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the quad potentiometer core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import qp_pkg::*;
   localparam int NVC = 50;
   localparam logic [3:0] DEVT = 4'hA; // arbitrary type code
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] strap = 2'h2;
   logic [1:0] adr = 2'h2;
   logic [3:0] typ = DEVT;
   logic sck, cs_n, si, so, so_oe_n, busy, rd_stb;
   logic [7:0] rd_byte;
   logic [CHANNELS*TAPS-1:0] tap;
   logic [7:0] nv_save_busy [4];
   logic [7:0] slt [4][4];
   logic [7:0] exp_q [$];
   logic [31:0] seed = 32'h000174EA;
   int fails = 0;
   int n_checks = 0;
   always #12.5 clk = ~clk;
   qp_core #(.DEV_TYPE(DEVT), .NV_SAVE_CYCLES(NVC)) i_qp_core (
      .clk_i(clk), .sys_rst_i(rst), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
      .so_o(so), .so_oe_n_o(so_oe_n), .strap_select_hi_i(strap[1]),
      .strap_select_lo_i(strap[0]), .tap_o(tap), .nv_save_busy_o(busy)
   );
   qp_host_model i_qp_host_model (
      .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_n_i(so_oe_n),
      .rd_stb_o(rd_stb), .rd_byte_o(rd_byte)
   );
   // ----------
   // Helpers
   // ----------
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   function automatic logic [31:0] cmd(input logic [3:0] op, input logic [1:0] sl,
      input logic [1:0] ch, input logic [7:0] d);
      return {typ, 2'h0, adr, op, sl, ch, d, 8'h00};
   endfunction
   task automatic check(input logic [255:0] got, input logic [255:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %0h, expected %0h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic send(input logic [31:0] w, input int n);
      i_qp_host_model.frame(w, n, 1'b0);
   endtask
   task automatic rd(input logic [3:0] op, input logic [1:0] sl, input logic [1:0] ch,
      input logic [7:0] e);
      exp_q.push_back(e);
      i_qp_host_model.frame(cmd(op, sl, ch, 8'h00), 24, 1'b1);
   endtask
   task automatic verify();
      repeat (380) @(posedge clk);
      for (int c = 0; c < CHANNELS; c++)
         check(tap[c*TAPS +: TAPS], 256'h1 << nv_save_busy[c]);
      for (int c = 0; c < CHANNELS; c++)
         rd(OP_RD_WIPER, 2'h0, c[1:0], nv_save_busy[c]);
   endtask
   always @(posedge rd_stb)
      check(rd_byte, exp_q.pop_front());
   initial begin
      #2ms;
      fails++;
      wrap_up();
   end
   // ----------
   // Main sequence
   // ----------
   initial begin
      foreach (slt[i, j]) slt[i][j] = SLOT_INIT;
      foreach (nv_save_busy[i]) nv_save_busy[i] = WIPER_RST;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      check(busy, 1'b0);
      check(so_oe_n, 1'b1);
      verify();
      for (int c = 0; c < CHANNELS; c++) begin
         nv_save_busy[c] = rnd();
         send(cmd(OP_WR_WIPER, 2'h0, c[1:0], nv_save_busy[c]), 24);
      end
      verify();
      send(cmd(OP_GLB_WIPER_TO_SLOT, 2'h0, 2'h0, 8'h00), 16);
      foreach (nv_save_busy[c]) slt[c][0] = nv_save_busy[c];
      repeat (NVC + 10) @(posedge clk);
      for (int s = 0; s < SLOTS; s++) begin
         slt[s][s] = rnd();
         send(cmd(OP_WR_SLOT, s[1:0], s[1:0], slt[s][s]), 24);
         check(busy, 1'b1);
         rd(OP_STATUS, 2'h0, 2'h1, 8'h01);
         check(busy, 1'b0);
         rd(OP_RD_SLOT, s[1:0], s[1:0], slt[s][s]);
      end
      send(cmd(OP_WR_WIPER, 2'h0, 2'h1, 8'hFE), 24);
      send(cmd(OP_WR_WIPER, 2'h0, 2'h2, 8'h01), 24);
      send(cmd(OP_STEP, 2'h0, 2'h1, 8'hC0), 20);
      send(cmd(OP_STEP, 2'h0, 2'h2, 8'h30), 20);
      nv_save_busy[1] = 8'hFD;
      nv_save_busy[2] = 8'h02;
      verify();
      send(cmd(OP_WIPER_TO_SLOT, 2'h2, 2'h1, 8'h00), 16);
      slt[1][2] = nv_save_busy[1];
      repeat (NVC + 10) @(posedge clk);
      for (int c = 0; c < CHANNELS; c++) begin
         send(cmd(OP_SLOT_TO_WIPER, c[1:0], c[1:0], 8'h00), 16);
         nv_save_busy[c] = slt[c][c];
      end
      verify();
      send(cmd(OP_GLB_SLOT_TO_WIPER, 2'h2, 2'h0, 8'h00), 16);
      foreach (nv_save_busy[c]) nv_save_busy[c] = slt[c][2];
      verify();
      for (int k = 0; k < 2; k++) begin
         typ = k ? 4'h3 : DEVT;
         adr = k ? 2'h2 : 2'h1;
         send(cmd(OP_WR_WIPER, 2'h0, 2'h0, ~nv_save_busy[0]), 24);
         rd(OP_RD_WIPER, 2'h0, 2'h0, 8'hXX);
      end
      typ = DEVT;
      // Reads after the strap move must carry the new address
      adr = 2'h1;
      @(posedge clk);
      strap <= 2'h1;
      verify();
      @(posedge clk);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      foreach (nv_save_busy[c]) nv_save_busy[c] = slt[c][0];
      verify();
      wrap_up();
   end
endmodule
`default_nettype wire
